// [shared/dpc_pkg.sv]
`default_nettype none
package dpc_pkg;

    // ------------------------------------------------------------
    // Clocking of the memory link
    // ------------------------------------------------------------
    localparam int CORE_PS = 10000;
    localparam int CK_DIV = 4;
    localparam int TCK_PS = CORE_PS * CK_DIV;

    // ------------------------------------------------------------
    // Burst length in data beats, latencies in memory clocks
    // ------------------------------------------------------------
    localparam int BL = 8;
    localparam int RL = 6;
    localparam int WL = 3;

    // ------------------------------------------------------------
    // Analog times in ps
    // ------------------------------------------------------------
    localparam int T_RPPB_PS = 18000;
    localparam int T_RPAB_PS = 21000;
    localparam int T_RAS_PS = 42000;
    localparam int T_RC_PS = 60000;
    localparam int T_RTP_PS = 7500;
    localparam int T_WR_PS = 15000;
    localparam int T_WTR_PS = 7500;
    localparam int T_DQSCK_PS = 5500;

    function automatic int ru(input int ps);
        int c;
        c = (ps + TCK_PS - 1) / TCK_PS;
        return (c < 1) ? 1 : c;
    endfunction : ru

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : imax

    // ------------------------------------------------------------
    // Spacings in memory clocks
    // ------------------------------------------------------------
    localparam int N_RPPB = ru(T_RPPB_PS);
    localparam int N_RPAB = ru(T_RPAB_PS);
    localparam int N_RAS = ru(T_RAS_PS);
    localparam int N_RC = ru(T_RC_PS);
    localparam int N_RD2PRE = BL / 2 + imax(4, ru(T_RTP_PS)) - 4;
    localparam int N_WR2PRE = WL + BL / 2 + ru(T_WR_PS) + 1;
    localparam int N_RDAP2ACT = N_RD2PRE + N_RPPB;
    localparam int N_WRAP2ACT = N_WR2PRE + N_RPPB;
    localparam int N_RD2WR = RL + BL / 2 + ru(T_DQSCK_PS) - WL + 1;
    localparam int N_WR2RD = WL + BL / 2 + ru(T_WTR_PS) + 1;
    localparam int N_RW2RW = BL / 2;
    localparam int N_PRE2PRE = 1;

    typedef logic [7:0] dpc_cnt_t;

    function automatic dpc_cnt_t ld(input int n);
        return dpc_cnt_t'(n);
    endfunction : ld

    // Count down, never below a freshly loaded spacing
    function automatic dpc_cnt_t dec_max(input dpc_cnt_t cur,
                                         input dpc_cnt_t n);
        dpc_cnt_t d;
        dpc_cnt_t m;
        d = (cur == 8'h00) ? 8'h00 : cur - 8'h01;
        m = (n == 8'h00) ? 8'h00 : n - 8'h01;
        return (d > m) ? d : m;
    endfunction : dec_max

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam int F_OP = 0;
    localparam int F_BANK = 4;
    localparam int F_ALL = 8;
    localparam int F_AP = 9;
    localparam int F_ADDR = 16;
    localparam int S_PEND = 0;
    localparam int S_REFUSED = 1;
    localparam int S_ILLEGAL = 2;
    localparam int S_RUN = 3;
    localparam int S_BANKS = 16;
    localparam logic RUN_RST = 1'b0;

    // ------------------------------------------------------------
    // Commands and pin encodings
    // ------------------------------------------------------------
    localparam logic [2:0] OP_ACT = 3'h1;
    localparam logic [2:0] OP_RD = 3'h2;
    localparam logic [2:0] OP_WR = 3'h3;
    localparam logic [2:0] OP_PRE = 3'h4;
    localparam logic [3:0] CA_ACT = 4'h2;
    localparam logic [3:0] CA_RD = 4'h5;
    localparam logic [3:0] CA_WR = 4'h1;
    localparam logic [3:0] CA_PRE = 4'hb;

    typedef enum logic [2:0] {
        BK_IDLE = 3'b001,
        BK_OPEN = 3'b010,
        BK_CLOSING = 3'b100
    } dpc_bank_e;

endpackage : dpc_pkg
`default_nettype wire

// [shared/dpc_bank_if.sv]
`default_nettype none
interface dpc_bank_if;
    logic tick;
    logic issue;
    logic [2:0] op;
    logic [2:0] bank;
    logic all_flag;
    logic ap;
    logic [7:0] act_ok;
    logic [7:0] pre_ok;
    logic [7:0] rw_ok;
    logic [15:0] state_code;

    modport ctl (
        output tick, issue, op, bank, all_flag, ap,
        input act_ok, pre_ok, rw_ok, state_code
    );
    modport trk (
        input tick, issue, op, bank, all_flag, ap,
        output act_ok, pre_ok, rw_ok, state_code
    );
endinterface : dpc_bank_if
`default_nettype wire

// [hw/dpc_bank_trk.sv]
`default_nettype none
module dpc_bank_trk
    import dpc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    dpc_bank_if.trk bi
);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i || !ce_i);

    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_bank
            dpc_cnt_t rp_r;
            dpc_cnt_t rc_r;
            dpc_cnt_t pre_r;
            dpc_bank_e st_r;
            dpc_bank_e st_nxt;
            wire logic hit = bi.issue && (bi.bank == 3'(b));
            wire logic act_hit = hit && (bi.op == OP_ACT);
            wire logic rd_hit = hit && (bi.op == OP_RD);
            wire logic wr_hit = hit && (bi.op == OP_WR);
            wire logic pre_hit = bi.issue && (bi.op == OP_PRE)
                && (bi.all_flag || bi.bank == 3'(b));
            wire logic ap_hit = (rd_hit || wr_hit) && bi.ap;
            // Precharge measured from latest close of this bank
            wire dpc_cnt_t rp_load = pre_hit ?
                (bi.all_flag ? ld(N_RPAB) : ld(N_RPPB)) :
                (rd_hit && bi.ap) ? ld(N_RDAP2ACT) :
                (wr_hit && bi.ap) ? ld(N_WRAP2ACT) :
                8'h00;
            wire dpc_cnt_t rc_load = act_hit ? ld(N_RC) : 8'h00;
            wire dpc_cnt_t pre_load = act_hit ? ld(N_RAS) :
                rd_hit ? ld(N_RD2PRE) :
                wr_hit ? ld(N_WR2PRE) : 8'h00;

            always_comb begin
                st_nxt = st_r;
                if (pre_hit || ap_hit) begin
                    st_nxt = BK_CLOSING;
                end else if (act_hit) begin
                    st_nxt = BK_OPEN;
                end else if (st_r == BK_CLOSING && rp_r <= 8'h01) begin
                    st_nxt = BK_IDLE;
                end
            end

            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    rp_r <= 8'h00;
                    rc_r <= 8'h00;
                    pre_r <= 8'h00;
                    st_r <= BK_IDLE;
                end else if (ce_i && bi.tick) begin
                    rp_r <= dec_max(rp_r, rp_load);
                    rc_r <= dec_max(rc_r, rc_load);
                    pre_r <= dec_max(pre_r, pre_load);
                    st_r <= st_nxt;
                end
            end

            assign bi.act_ok[b] = (rp_r == 8'h00) && (rc_r == 8'h00)
                && (st_r != BK_OPEN);
            assign bi.pre_ok[b] = (pre_r == 8'h00);
            assign bi.rw_ok[b] = (st_r == BK_OPEN);
            assign bi.state_code[2*b+1:2*b] =
                (st_r == BK_OPEN) ? 2'b01 :
                (st_r == BK_CLOSING) ? 2'b10 : 2'b00;

            // ----------------------------------------------------
            // Checks
            // ----------------------------------------------------
            chk_pre_blocks_act: assert property (
                act_hit |-> rp_r == 8'h00 && rc_r == 8'h00)
                else $error("activate inside precharge or cycle time");
            chk_act_blocks_pre: assert property (
                act_hit |=> !bi.pre_ok[b] [*4])
                else $error("close allowed right after activate");
            chk_ap_closes: assert property (
                ap_hit |=> st_r == BK_CLOSING)
                else $error("self-close did not start closing");
            chk_noap_stays: assert property (
                (rd_hit || wr_hit) && !bi.ap |=> st_r == BK_OPEN)
                else $error("plain access closed the bank");
            chk_all_closes: assert property (
                bi.issue && bi.op == OP_PRE && bi.all_flag
                |=> st_r == BK_CLOSING)
                else $error("all-bank close missed a bank");
        end
    endgenerate

endmodule : dpc_bank_trk
`default_nettype wire

// [hw/dpc_host.sv]
`default_nettype none
module dpc_host
    import dpc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    output logic mem_ck_o,
    output logic mem_ck_n_o,
    output logic mem_cs_n_o,
    output logic [9:0] mem_ca_o
);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i || !ce_i);

    dpc_bank_if bi ();

    dpc_bank_trk u_trk (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .bi(bi.trk)
    );

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wph_r;
    logic [7:0] wadr_r;
    logic ready_r;
    logic [31:0] rdata_r;
    logic pend_r;
    logic [2:0] op_r;
    logic [2:0] bank_r;
    logic all_r;
    logic ap_r;
    logic [10:0] addr_r;
    logic refused_r;
    logic illegal_r;
    logic run_r;

    wire logic ap_valid = hsel_i && htrans_i[1] && hready_i;
    wire logic cmd_wr = wph_r && (wadr_r == A_CMD);
    wire logic stat_wr = wph_r && (wadr_r == A_STAT);
    wire logic ctrl_wr = wph_r && (wadr_r == A_CTRL);
    wire logic [31:0] stat_word = {bi.state_code, 12'h000, run_r,
        illegal_r, refused_r, pend_r};
    wire logic [31:0] rdata_mux =
        (haddr_i[7:0] == A_STAT) ? stat_word :
        (haddr_i[7:0] == A_CTRL) ? {31'h0, run_r} : 32'h0;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wph_r <= 1'b0;
            wadr_r <= 8'h00;
            ready_r <= 1'b0;
            rdata_r <= 32'h0;
        end else if (ce_i) begin
            ready_r <= 1'b1;
            wph_r <= ap_valid && hwrite_i;
            wadr_r <= haddr_i[7:0];
            if (ap_valid && !hwrite_i) begin
                rdata_r <= rdata_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Link clock divider
    // ------------------------------------------------------------
    logic [1:0] div_r;
    logic ck_r;
    logic ck_n_r;
    wire logic [1:0] div_nxt = run_r ? div_r + 2'd1 : div_r;
    wire logic ck_nxt = (div_nxt == 2'd1) || (div_nxt == 2'd2);
    wire logic tick = run_r && (div_r == 2'd3);
    wire logic half = run_r && (div_r == 2'd1);

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_r <= 2'd0;
            ck_r <= 1'b0;
            ck_n_r <= 1'b1;
        end else if (ce_i) begin
            div_r <= div_nxt;
            ck_r <= ck_nxt;
            ck_n_r <= !ck_nxt;
        end
    end

    // ------------------------------------------------------------
    // Command legality
    // ------------------------------------------------------------
    dpc_cnt_t rw_r;
    dpc_cnt_t rd2wr_r;
    dpc_cnt_t wr2rd_r;
    dpc_cnt_t pp_r;

    wire logic is_act = (op_r == OP_ACT);
    wire logic is_rd = (op_r == OP_RD);
    wire logic is_wr = (op_r == OP_WR);
    wire logic is_pre = (op_r == OP_PRE);
    wire logic bank_open = bi.rw_ok[bank_r];
    wire logic bad_op = !(is_act || is_rd || is_wr || is_pre);
    wire logic illegal = bad_op
        || ((is_rd || is_wr) && !bank_open)
        || (is_act && bank_open);
    wire logic pre_time = (pp_r == 8'h00)
        && (all_r ? (&bi.pre_ok) : bi.pre_ok[bank_r]);
    wire logic timing_ok =
        (is_act && bi.act_ok[bank_r]) ||
        (is_pre && pre_time) ||
        (is_rd && rw_r == 8'h00 && wr2rd_r == 8'h00) ||
        (is_wr && rw_r == 8'h00 && rd2wr_r == 8'h00);
    wire logic go = tick && pend_r && !illegal && timing_ok;
    wire logic drop = tick && pend_r && illegal;

    assign bi.tick = tick;
    assign bi.issue = go;
    assign bi.op = op_r;
    assign bi.bank = bank_r;
    assign bi.all_flag = all_r;
    assign bi.ap = ap_r;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rw_r <= 8'h00;
            rd2wr_r <= 8'h00;
            wr2rd_r <= 8'h00;
            pp_r <= 8'h00;
        end else if (ce_i && tick) begin
            rw_r <= dec_max(rw_r, (go && (is_rd || is_wr)) ?
                ld(N_RW2RW) : 8'h00);
            rd2wr_r <= dec_max(rd2wr_r, (go && is_rd) ?
                ld(N_RD2WR) : 8'h00);
            wr2rd_r <= dec_max(wr2rd_r, (go && is_wr) ?
                ld(N_WR2RD) : 8'h00);
            pp_r <= dec_max(pp_r, (go && is_pre) ?
                ld(N_PRE2PRE) : 8'h00);
        end
    end

    // ------------------------------------------------------------
    // Order register and flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_r <= 1'b0;
            op_r <= 3'h0;
            bank_r <= 3'h0;
            all_r <= 1'b0;
            ap_r <= 1'b0;
            addr_r <= 11'h0;
            refused_r <= 1'b0;
            illegal_r <= 1'b0;
            run_r <= RUN_RST;
        end else if (ce_i) begin
            if (go || drop) begin
                pend_r <= 1'b0;
            end else if (cmd_wr && !pend_r) begin
                pend_r <= 1'b1;
                op_r <= hwdata_i[F_OP+:3];
                bank_r <= hwdata_i[F_BANK+:3];
                all_r <= hwdata_i[F_ALL];
                ap_r <= hwdata_i[F_AP];
                addr_r <= hwdata_i[F_ADDR+:11];
            end
            // Set beats a clear in the same cycle
            if (cmd_wr && pend_r) begin
                refused_r <= 1'b1;
            end else if (stat_wr && hwdata_i[S_REFUSED]) begin
                refused_r <= 1'b0;
            end
            if (drop) begin
                illegal_r <= 1'b1;
            end else if (stat_wr && hwdata_i[S_ILLEGAL]) begin
                illegal_r <= 1'b0;
            end
            if (ctrl_wr) begin
                run_r <= hwdata_i[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    logic cs_n_r;
    logic [9:0] ca_r;
    logic [9:0] fall_r;

    wire logic [3:0] ca_op = is_act ? CA_ACT : is_rd ? CA_RD :
        is_wr ? CA_WR : CA_PRE;
    wire logic [9:0] rise_word = {bank_r, addr_r[1:0],
        is_pre && all_r, ca_op};
    wire logic [9:0] fall_word = {addr_r[10:2],
        (is_rd || is_wr) && ap_r};

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_n_r <= 1'b1;
            ca_r <= 10'h000;
            fall_r <= 10'h000;
        end else if (ce_i) begin
            if (tick) begin
                cs_n_r <= !go;
                ca_r <= go ? rise_word : 10'h000;
                fall_r <= go ? fall_word : 10'h000;
            end else if (half) begin
                cs_n_r <= 1'b1;
                ca_r <= fall_r;
            end
        end
    end

    assign hreadyout_o = ready_r;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_r;
    assign mem_ck_o = ck_r;
    assign mem_ck_n_o = ck_n_r;
    assign mem_cs_n_o = cs_n_r;
    assign mem_ca_o = ca_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [15:0] rd_age_r;
    logic [15:0] wr_age_r;
    logic [15:0] pre_age_r;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_age_r <= 16'hffff;
            wr_age_r <= 16'hffff;
            pre_age_r <= 16'hffff;
        end else if (ce_i) begin
            rd_age_r <= (go && is_rd) ? 16'h0001 :
                (rd_age_r == 16'hffff) ? rd_age_r : rd_age_r + 16'h1;
            wr_age_r <= (go && is_wr) ? 16'h0001 :
                (wr_age_r == 16'hffff) ? wr_age_r : wr_age_r + 16'h1;
            pre_age_r <= (go && is_pre) ? 16'h0001 :
                (pre_age_r == 16'hffff) ? pre_age_r : pre_age_r + 16'h1;
        end
    end

    chk_rd_to_wr: assert property (
        go && is_wr |-> rd_age_r >= 16'(N_RD2WR * CK_DIV))
        else $error("write too soon after read");
    chk_wr_to_rd: assert property (
        go && is_rd |-> wr_age_r >= 16'(N_WR2RD * CK_DIV))
        else $error("read too soon after write");
    chk_rw_gap: assert property (
        go && (is_rd || is_wr) |-> rd_age_r >= 16'(N_RW2RW * CK_DIV)
        && wr_age_r >= 16'(N_RW2RW * CK_DIV))
        else $error("access cuts a running burst");
    chk_pre_space: assert property (
        go && is_pre |-> pre_age_r >= 16'(N_PRE2PRE * CK_DIV))
        else $error("closes spaced under one clock");
    chk_illegal_drop: assert property (
        drop |=> illegal_r && !pend_r && cs_n_r)
        else $error("illegal access not dropped");
    chk_pend_holds: assert property (
        pend_r && !go && !drop |=> pend_r)
        else $error("order lost while waiting");
    chk_cs_pulse: assert property (
        go |=> !mem_cs_n_o [*2] ##1 mem_cs_n_o)
        else $error("chip select pulse has wrong length");

    cov_rd_ap: cover property (go && is_rd && ap_r);
    cov_pre_all: cover property (go && is_pre && all_r);
    cov_drop: cover property (drop);
    cov_wr_rd: cover property (go && is_rd && wr_age_r < 16'd200);

endmodule : dpc_host
`default_nettype wire

// [sim/dpc_dev_model.sv]
`default_nettype none
module dpc_dev_model
    import dpc_pkg::*;
(
    input wire logic mem_ck_i,
    input wire logic mem_cs_n_i,
    input wire logic [9:0] mem_ca_i,
    output logic [7:0] open_o,
    output logic err_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Rising word capture, decode once the falling word is in
    // ------------------------------------------------------------
    logic [9:0] rise_r = 10'h000;
    logic sel_r = 1'b0;
    logic [2:0] b;

    initial begin
        open_o = 8'h00;
        err_o = 1'b0;
    end

    always @(posedge mem_ck_i) begin
        sel_r <= !mem_cs_n_i;
        rise_r <= mem_ca_i;
    end

    always @(negedge mem_ck_i) begin
        b = rise_r[9:7];
        if (sel_r) begin
            case (rise_r[3:0])
                CA_ACT: begin
                    err_o = err_o | open_o[b];
                    open_o[b] = 1'b1;
                end
                // Bank must be open, bank closed only with self-close
                CA_RD, CA_WR: begin
                    err_o = err_o | !open_o[b];
                    if (mem_ca_i[0]) open_o[b] = 1'b0;
                end
                CA_PRE: begin
                    if (rise_r[4]) open_o = 8'h00;
                    else open_o[b] = 1'b0;
                end
                default: err_o = 1'b1;
            endcase
        end
    end
endmodule : dpc_dev_model
`default_nettype wire

// [sim/tb_dpc_host.sv]
`default_nettype none
module tb_dpc_host
    import dpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic ck;
    logic cs_n;
    logic [9:0] ca;
    logic ck_n;
    logic hresp;
    logic ce = 1'b1;
    logic [7:0] open;
    logic err;
    logic cs_q = 1'b1;
    logic [31:0] rd = 32'h0;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    int last_cs = 0;
    int gap = 0;

    always #5 core_clk = ~core_clk;

    dpc_host dut (
        .core_clk_i(core_clk), .nrst_i(nrst), .ce_i(ce),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .mem_ck_o(ck), .mem_ck_n_o(ck_n),
        .mem_cs_n_o(cs_n), .mem_ca_o(ca)
    );

    dpc_dev_model dev (
        .mem_ck_i(ck), .mem_cs_n_i(cs_n), .mem_ca_i(ca),
        .open_o(open), .err_o(err)
    );

    // ------------------------------------------------------------
    // Command spacing monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        cs_q <= cs_n;
        if (cs_q && !cs_n) begin
            gap <= cyc - last_cs;
            last_cs <= cyc;
        end
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            results();
        end
    end

    task automatic results;
        if (mismatches == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            $display("wrong value %s exp %h got %h", nm, exp, got);
            mismatches = mismatches + 1;
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    // Wait for the order to leave, then check its spacing
    task automatic settle(input int mn);
        int i;
        i = 0;
        rd = 32'h1;
        while (rd[S_PEND] !== 1'b0 && i < 200) begin
            xfer(1'b0, A_STAT, 32'h0);
            i++;
        end
        chk("pend", 32'h0, {31'h0, rd[S_PEND]});
        // Let the model decode the falling word first
        repeat (2) @(posedge core_clk);
        if (mn > 0) chk("gap", 32'h1, {31'h0, gap >= mn * CK_DIV});
    endtask : settle

    task automatic cmd(input logic [2:0] op, input logic [2:0] b,
                       input logic al, input logic ap, input int mn);
        xfer(1'b1, A_CMD, {22'h0, ap, al, 1'b0, b, 1'b0, op});
        settle(mn);
    endtask : cmd

    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        xfer(1'b0, A_STAT, 32'h0);
        chk("status", 32'h0, rd);
        xfer(1'b0, A_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        xfer(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, rd);
        xfer(1'b1, A_CMD, 32'h11);
        xfer(1'b1, A_CMD, 32'h11);
        xfer(1'b0, A_STAT, 32'h0);
        chk("refused", 32'h3, rd);
        xfer(1'b1, A_STAT, 32'h2);
        xfer(1'b1, A_CTRL, 32'h1);
        settle(0);
        xfer(1'b0, A_STAT, 32'h0);
        chk("status", 32'h0004_0008, rd);
        chk("open", 32'h2, {24'h0, open});
        cmd(OP_RD, 3'h1, 1'b0, 1'b1, 0);
        chk("open", 32'h0, {24'h0, open});
        cmd(OP_RD, 3'h1, 1'b0, 1'b0, 0);
        xfer(1'b0, A_STAT, 32'h0);
        chk("illegal", 32'h4, rd & 32'h4);
        xfer(1'b1, A_STAT, 32'h4);
        xfer(1'b0, A_STAT, 32'h0);
        chk("w1c", 32'h0, rd & 32'h6);
        cmd(OP_ACT, 3'h3, 1'b0, 1'b0, 0);
        cmd(OP_PRE, 3'h3, 1'b0, 1'b0, N_RAS);
        cmd(OP_ACT, 3'h3, 1'b0, 1'b0, N_RPPB);
        cmd(OP_RD, 3'h3, 1'b0, 1'b0, 0);
        chk("open", 32'h8, {24'h0, open});
        cmd(OP_PRE, 3'h3, 1'b0, 1'b0, N_RD2PRE);
        cmd(OP_ACT, 3'h3, 1'b0, 1'b0, N_RPPB);
        cmd(OP_ACT, 3'h5, 1'b0, 1'b0, 0);
        cmd(OP_WR, 3'h3, 1'b0, 1'b0, 0);
        cmd(OP_PRE, 3'h0, 1'b1, 1'b0, N_WR2PRE);
        chk("open", 32'h0, {24'h0, open});
        cmd(OP_PRE, 3'h2, 1'b0, 1'b0, N_PRE2PRE);
        cmd(OP_ACT, 3'h4, 1'b0, 1'b0, 0);
        cmd(OP_ACT, 3'h6, 1'b0, 1'b0, 0);
        cmd(OP_RD, 3'h4, 1'b0, 1'b1, 0);
        cmd(OP_RD, 3'h6, 1'b0, 1'b0, N_RW2RW);
        cmd(OP_WR, 3'h6, 1'b0, 1'b0, N_RD2WR);
        cmd(OP_WR, 3'h6, 1'b0, 1'b1, N_RW2RW);
        cmd(OP_ACT, 3'h6, 1'b0, 1'b0, N_WRAP2ACT);
        cmd(OP_ACT, 3'h4, 1'b0, 1'b0, 0);
        chk("open", 32'h50, {24'h0, open});
        chk("model", 32'h0, {31'h0, err});
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("ck_n", {31'h0, !ck}, {31'h0, ck_n});
        // Clock enable low freezes the link clock
        ce <= 1'b0;
        @(posedge core_clk);
        rd = {30'h0, cs_n, ck};
        repeat (6) @(posedge core_clk);
        chk("frozen", rd, {30'h0, cs_n, ck});
        ce <= 1'b1;
        results();
    end
endmodule : tb_dpc_host
`default_nettype wire
